//--- hdl/ldb_pkg.sv
// constants, register map and carrier types of the led driver control block
// assumes a 200 MHz pclk; nothing else outside is needed
package ldb_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned STEP_NS        = 40;     // channel pwm step
  localparam int unsigned STEP_CYC       = STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned GRP_STEP_NS    = 20480;  // group dimming step
  localparam int unsigned GRP_STEP_CYC   = GRP_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned BLINK_STEP_NS  = 162760; // 1/(24 Hz * 256)
  localparam logic [2:0]  STEP_LAST      = 3'(STEP_CYC - 1);
  localparam logic [11:0] GRP_LAST       = 12'(GRP_STEP_CYC - 1);

  // sizes
  localparam int unsigned NCH            = 16;

  // register byte offsets
  localparam logic [11:0] OFS_MODE_CONTROL_SECOND      = 12'h000; // mode_control_second
  localparam logic [11:0] OFS_GRP_DUTY   = 12'h004; // group_duty_value
  localparam logic [11:0] OFS_BLINK      = 12'h008; // blink period
  localparam logic [11:0] OFS_LATCH      = 12'h00C; // output control latch
  localparam logic [11:0] OFS_EFLAG_HI   = 12'h010; // error_flags_high
  localparam logic [11:0] OFS_EFLAG_LO   = 12'h014; // error_flags_low
  localparam logic [11:0] OFS_STATUS     = 12'h018; // live state
  localparam logic [11:0] OFS_DUTY_BASE  = 12'h040; // channel_duty_value 0..15

  // field positions
  localparam int unsigned MODE_GRPEN_BIT = 0;      // apply group signal
  localparam int unsigned MODE_BLINK_BIT = 5;      // 1 blink, 0 dimming
  localparam int unsigned MODE_OTCLR_BIT = 7;      // clear overtemp status
  localparam int unsigned STAT_GATE_BIT  = 3;
  localparam int unsigned STAT_HOT_BIT   = 2;

  // reset values
  localparam logic [7:0]  MODE_RST       = 8'h00;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  localparam logic [15:0] LATCH_RST      = 16'h0000;
  localparam logic [15:0] EFLAG_RST      = 16'hFFFF;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  // software reset call
  localparam logic [7:0]  SOFTWARE_RESET_CALL_ADDR_W   = 8'hD6;
  localparam logic [7:0]  SOFTWARE_RESET_CALL_KEY1     = 8'hA5;
  localparam logic [7:0]  SOFTWARE_RESET_CALL_KEY2     = 8'h5A;
  localparam logic [3:0]  BITS_PER_BYTE  = 4'h8;

  typedef enum logic [1:0] {
    I2C_IDLE = 2'b00,
    I2C_RECV = 2'b01,
    I2C_ACK  = 2'b10,
    I2C_SKIP = 2'b11
  } ldb_i2c_st_t;

  // analog sensor and comparator levels, one bit per channel besides the single global overtemp bit
  typedef struct packed {
    logic        glob_hot;
    logic [15:0] chan_hot;
    logic [15:0] chan_open;
  } ldb_sense_t;

  // reset level for the pin synchronisers: sensors 0, pins idle high
  localparam logic [35:0] SYNC_RST       = 36'h0_0000_0007;

endpackage : ldb_pkg

//--- hdl/ldb_top.sv
// led driver control: apb registers, software reset call slave on the
// two-wire bus, overtemperature and open-load error status, pwm outputs
// assumes sensors, scl, sda and the reset pin are asynchronous levels
//
// How it works
// - global overtemp: all off, all flagged
// - channel overtemp: only that channel off, flagged
// - cooled channels restart if latch still on
// - overtemp status latched until host clears
// - channel overtemp recorded only while on
// - open-load and overtemp faults are ORed
// - mode bit 7 high clears, low re-enables
// - status bit 1 normal, 0 on fault
// - power-on reset gives all defaults, outputs off
// - reset pin low holds all but the channel pwm and prescaler counters at default
// - ack reset call address on write only
// - ack first key only if A5h
// - ack second key only if 5Ah
// - no ack for bytes after both keys
// - stop after both keys resets the device
// - any deviation aborts, no reset
// - per-channel 8-bit pwm, 40 ns step
// - group dimming pwm gates channels, 20.48 us step
// - group blinking with 8-bit period instead
// - start and stop seen while scl high
// - receiver holds sda low in ninth clock
// - never transmits, so sda stays released outside the ack
// - flag registers upper and lower eight, default ones
// - on channel below threshold records open-load
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
module ldb_top
  import ldb_pkg::*;
#(
  parameter int unsigned BLINK_STEP_CYC = BLINK_STEP_NS / CLK_PERIOD_NS
) (
  input  wire logic        pclk,      // 200 MHz clock
  input  wire logic        presetn,   // power-on reset, active low
  input  wire logic        psel,      // apb select
  input  wire logic        penable,   // apb access phase
  input  wire logic        pwrite,    // apb direction
  input  wire logic [11:0] paddr,     // apb byte address
  input  wire logic [31:0] pwdata,    // apb write data
  output logic      [31:0] prdata,    // apb read data
  output logic             pready,    // apb ready
  output logic             pslverr,   // apb error on unmapped address
  input  wire logic        rst_pin_n, // external reset pin
  input  wire logic        scl_in,    // bus clock level
  input  wire logic        sda_in,    // bus data level
  output logic             sda_out,   // sda drive value, always low
  output logic             sda_oe,    // high while pulling sda low
  input  wire ldb_sense_t  sense,     // thermal and open-load sensors
  output logic      [15:0] led_out    // channel sink enables
);
  localparam int unsigned SYNC_W    = 36;
  localparam logic [15:0] BLINK_LAST = 16'(BLINK_STEP_CYC - 1);
  function automatic logic is_duty(input logic [11:0] a);
    is_duty = (a[11:6] == OFS_DUTY_BASE[11:6]) && (a[1:0] == 2'b00);
  endfunction : is_duty
  function automatic logic key_ok(input logic [1:0] idx,
                                  input logic [7:0] b);
    case (idx)
      2'd0:    key_ok = (b == SOFTWARE_RESET_CALL_ADDR_W);
      2'd1:    key_ok = (b == SOFTWARE_RESET_CALL_KEY1);
      2'd2:    key_ok = (b == SOFTWARE_RESET_CALL_KEY2);
      default: key_ok = 1'b0;
    endcase
  endfunction : key_ok
  // ---------------- pin synchronisers and filter
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1_q, s2_q, s3_q;
  logic [SYNC_W-1:0] flt_q, flt_d;
  ldb_sense_t        sense_f;
  logic              pin_n_f, scl_f, sda_f;
  assign raw = {sense, rst_pin_n, scl_in, sda_in};
  // a level counts once stages two and three agree
  for (genvar g = 0; g < SYNC_W; g++) begin : g_flt
    assign flt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
  end
  // three-stage synchroniser chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q  <= SYNC_RST;
      s2_q  <= SYNC_RST;
      s3_q  <= SYNC_RST;
      flt_q <= SYNC_RST;
    end else begin
      s1_q  <= raw;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      flt_q <= flt_d;
    end
  end
  assign sense_f = flt_q[SYNC_W-1:3];
  assign pin_n_f = flt_q[2];
  assign scl_f   = flt_q[1];
  assign sda_f   = flt_q[0];
  // ---------------- two-wire slave for the reset call
  ldb_i2c_st_t st_q, st_d;
  logic [3:0]  bit_q, bit_d;
  logic [1:0]  idx_q, idx_d;
  logic [7:0]  sh_q, sh_d;
  logic        armed_q, armed_d;
  logic        oe_q, oe_d;
  logic        software_reset_call_q, software_reset_call_d;
  logic        scl_p_q, sda_p_q;
  logic        scl_rise, scl_fall, bus_start, bus_stop, soft_clr;
  assign scl_rise  = scl_f & ~scl_p_q;
  assign scl_fall  = ~scl_f & scl_p_q;
  assign bus_start = scl_f & scl_p_q & ~sda_f & sda_p_q;
  assign bus_stop  = scl_f & scl_p_q & sda_f & ~sda_p_q;
  assign soft_clr  = ~pin_n_f | software_reset_call_q;
  // slave next state
  always_comb begin
    st_d    = st_q;
    bit_d   = bit_q;
    idx_d   = idx_q;
    sh_d    = sh_q;
    armed_d = armed_q;
    oe_d    = oe_q;
    software_reset_call_d = 1'b0;
    if (!pin_n_f || bus_start) begin
      st_d    = pin_n_f ? I2C_RECV : I2C_IDLE;
      bit_d   = 4'h0;
      idx_d   = 2'd0;
      armed_d = 1'b0;
      oe_d    = 1'b0;
    end else if (bus_stop) begin
      software_reset_call_d = armed_q;
      armed_d = 1'b0;
      st_d    = I2C_IDLE;
      oe_d    = 1'b0;
    end else begin
      case (st_q)
        I2C_RECV: begin
          if (scl_rise && (bit_q < BITS_PER_BYTE)) begin
            sh_d  = {sh_q[6:0], sda_f};
            bit_d = 4'(bit_q + 4'h1);
          end else if (scl_fall && (bit_q == BITS_PER_BYTE)) begin
            if (key_ok(idx_q, sh_q)) begin
              st_d    = I2C_ACK;
              oe_d    = 1'b1;
              armed_d = (idx_q == 2'd2);
            end else begin
              st_d    = I2C_SKIP;
              armed_d = 1'b0;
            end
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            oe_d  = 1'b0;
            bit_d = 4'h0;
            idx_d = (idx_q == 2'd3) ? idx_q : 2'(idx_q + 2'd1);
            st_d  = I2C_RECV;
          end
        end
        I2C_SKIP: st_d = I2C_SKIP;
        I2C_IDLE: st_d = I2C_IDLE;
        default:  st_d = I2C_IDLE;
      endcase
    end
  end
  // slave registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= I2C_IDLE;
      bit_q   <= 4'h0;
      idx_q   <= 2'd0;
      sh_q    <= BYTE_RST;
      armed_q <= 1'b0;
      oe_q    <= 1'b0;
      software_reset_call_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      bit_q   <= bit_d;
      idx_q   <= idx_d;
      sh_q    <= sh_d;
      armed_q <= armed_d;
      oe_q    <= oe_d;
      software_reset_call_q <= software_reset_call_d;
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
    end
  end
  assign sda_oe  = oe_q;
  assign sda_out = 1'b0;
  // ---------------- software registers and apb slave
  logic [7:0]  mode_q, mode_d;
  logic [7:0]  gduty_q, gduty_d;
  logic [7:0]  blink_q, blink_d;
  logic [15:0] latch_q, latch_d;
  logic [7:0]  duty_q [NCH];
  logic [7:0]  duty_d [NCH];
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, perr_q, perr_d;
  logic [31:0] rd_mux;
  logic        mapped, setup, wr_en;
  logic [15:0] shut, open_flt, flags, err_q, err_d;
  logic        grp_gate;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_q & pwrite & ~perr_q;
  // address decode and read mux
  always_comb begin
    mapped = 1'b1;
    rd_mux = RDATA_RST;
    if (is_duty(paddr)) begin
      rd_mux[7:0] = duty_q[paddr[5:2]];
    end else begin
      case (paddr)
        OFS_MODE_CONTROL_SECOND:    rd_mux[7:0]  = mode_q;
        OFS_GRP_DUTY: rd_mux[7:0]  = gduty_q;
        OFS_BLINK:    rd_mux[7:0]  = blink_q;
        OFS_LATCH:    rd_mux[15:0] = latch_q;
        OFS_EFLAG_HI: rd_mux[7:0]  = flags[15:8];
        OFS_EFLAG_LO: rd_mux[7:0]  = flags[7:0];
        OFS_STATUS: begin
          rd_mux[1:0]           = st_q;
          rd_mux[STAT_HOT_BIT]  = sense_f.glob_hot;
          rd_mux[STAT_GATE_BIT] = grp_gate;
          rd_mux[31:16]         = sense_f.chan_hot;
        end
        default:      mapped       = 1'b0;
      endcase
    end
  end
  // register next values; pin and call resets restore defaults
  always_comb begin
    mode_d   = mode_q;
    gduty_d  = gduty_q;
    blink_d  = blink_q;
    latch_d  = latch_q;
    duty_d   = duty_q;
    pready_d = setup;
    perr_d   = setup & ~mapped;
    prdata_d = (setup & ~pwrite & mapped) ? rd_mux : RDATA_RST;
    if (soft_clr) begin
      mode_d  = MODE_RST;
      gduty_d = BYTE_RST;
      blink_d = BYTE_RST;
      latch_d = LATCH_RST;
      for (int i = 0; i < NCH; i++) begin
        duty_d[i] = BYTE_RST;
      end
    end else if (wr_en) begin
      if (is_duty(paddr)) begin
        duty_d[paddr[5:2]] = pwdata[7:0];
      end else begin
        case (paddr)
          OFS_MODE_CONTROL_SECOND:    mode_d  = pwdata[7:0];
          OFS_GRP_DUTY: gduty_d = pwdata[7:0];
          OFS_BLINK:    blink_d = pwdata[7:0];
          OFS_LATCH:    latch_d = pwdata[15:0];
          default:      mode_d  = mode_q;
        endcase
      end
    end
  end
  // register storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= MODE_RST;
      gduty_q  <= BYTE_RST;
      blink_q  <= BYTE_RST;
      latch_q  <= LATCH_RST;
      for (int i = 0; i < NCH; i++) begin
        duty_q[i] <= BYTE_RST;
      end
      prdata_q <= RDATA_RST;
      pready_q <= 1'b0;
      perr_q   <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      gduty_q  <= gduty_d;
      blink_q  <= blink_d;
      latch_q  <= latch_d;
      duty_q   <= duty_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      perr_q   <= perr_d;
    end
  end
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = perr_q;
  // ---------------- error status
  assign shut     = {NCH{sense_f.glob_hot}} | sense_f.chan_hot;
  assign open_flt = latch_q & ~shut & sense_f.chan_open;
  assign flags    = err_q & ~open_flt;
  // overtemp status: 1 normal, 0 latched fault
  always_comb begin
    if (soft_clr || mode_q[MODE_OTCLR_BIT]) begin
      err_d = EFLAG_RST;
    end else begin
      err_d = err_q & ~({NCH{sense_f.glob_hot}}
                        | (sense_f.chan_hot & latch_q));
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= EFLAG_RST;
    end else begin
      err_q <= err_d;
    end
  end
  // ---------------- pwm generation
  logic [2:0]  step_q, step_d;
  logic [7:0]  ccnt_q, ccnt_d;
  logic [11:0] gdiv_q, gdiv_d;
  logic [15:0] bdiv_q, bdiv_d;
  logic [7:0]  bsub_q, bsub_d;
  logic [7:0]  gcnt_q, gcnt_d;
  logic [15:0] led_q, led_d, ch_pwm;
  logic        dim_tick, blk_tick, grp_tick;
  for (genvar c = 0; c < NCH; c++) begin : g_pwm
    assign ch_pwm[c] = ccnt_q < duty_q[c];
  end
  assign dim_tick = (gdiv_q == GRP_LAST);
  assign blk_tick = (bdiv_q == BLINK_LAST) && (bsub_q == blink_q);
  assign grp_tick = mode_q[MODE_BLINK_BIT] ? blk_tick : dim_tick;
  assign grp_gate = ~mode_q[MODE_GRPEN_BIT] | (gcnt_q < gduty_q);
  // counters and output gating
  always_comb begin
    step_d = (step_q == STEP_LAST) ? 3'h0 : 3'(step_q + 3'h1);
    ccnt_d = (step_q == STEP_LAST) ? 8'(ccnt_q + 8'h1) : ccnt_q;
    gdiv_d = dim_tick ? 12'h000 : 12'(gdiv_q + 12'h001);
    bdiv_d = (bdiv_q == BLINK_LAST) ? 16'h0000 : 16'(bdiv_q + 16'h0001);
    bsub_d = bsub_q;
    if (bdiv_q == BLINK_LAST) begin
      bsub_d = (bsub_q == blink_q) ? 8'h00 : 8'(bsub_q + 8'h01);
    end
    gcnt_d = grp_tick ? 8'(gcnt_q + 8'h01) : gcnt_q;
    led_d  = latch_q & ~shut & ch_pwm & {NCH{grp_gate}};
    if (soft_clr) begin
      led_d  = LATCH_RST;
      gcnt_d = BYTE_RST;
      bsub_d = BYTE_RST;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= 3'h0;
      ccnt_q <= BYTE_RST;
      gdiv_q <= 12'h000;
      bdiv_q <= 16'h0000;
      bsub_q <= BYTE_RST;
      gcnt_q <= BYTE_RST;
      led_q  <= LATCH_RST;
    end else begin
      step_q <= step_d;
      ccnt_q <= ccnt_d;
      gdiv_q <= gdiv_d;
      bdiv_q <= bdiv_d;
      bsub_q <= bsub_d;
      gcnt_q <= gcnt_d;
      led_q  <= led_d;
    end
  end
  assign led_out = led_q;
endmodule : ldb_top

//--- verification/ldb_checker.sv
// port checker for the led driver control block
// bound into ldb_top; sees only its ports
`timescale 1ns/1ps
module ldb_checker
  import ldb_pkg::*;
#(
  parameter int unsigned BLINK_STEP_CYC = 4
) (
  input wire logic        pclk,      // clock
  input wire logic        presetn,   // reset, active low
  input wire logic        psel,      // apb select
  input wire logic        penable,   // apb access
  input wire logic        pwrite,    // apb direction
  input wire logic [11:0] paddr,     // apb address
  input wire logic [31:0] pwdata,    // apb write data
  input wire logic [31:0] prdata,    // apb read data
  input wire logic        pready,    // apb ready
  input wire logic        pslverr,   // apb error
  input wire logic        rst_pin_n, // reset pin
  input wire logic        scl_in,    // bus clock
  input wire logic        sda_in,    // bus data
  input wire logic        sda_out,   // sda value
  input wire logic        sda_oe,    // sda pull enable
  input wire ldb_sense_t  sense,     // sensors
  input wire logic [15:0] led_out    // channel enables
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // apb handshake timing
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  // faults and resets darken outputs
  a_glob_off: assert property (sense.glob_hot [*8] |-> led_out == 16'h0000)
    else $error("output on during global trip");
  a_chan_off: assert property (sense.chan_hot[3] [*8] |-> !led_out[3])
    else $error("channel on during its trip");
  a_pin_hold: assert property (!rst_pin_n [*8] |-> led_out == 16'h0000)
    else $error("output on while pin reset");
  a_reset_dark: assert property ($rose(presetn) |-> led_out == 16'h0000)
    else $error("output on after reset");
  // acknowledge drive on the two-wire bus
  a_ack_low: assert property (sda_oe |-> sda_out == 1'b0)
    else $error("sda driven high");
  a_ack_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed while scl high");

  c_ack: cover property (sda_oe);
  c_err: cover property (pslverr);
  c_glob: cover property (sense.glob_hot && led_out == 16'h0000);
endmodule : ldb_checker

bind ldb_top ldb_checker #(.BLINK_STEP_CYC(BLINK_STEP_CYC)) ldb_checker_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .sense(sense), .led_out(led_out));

//--- verification/ldb_i2c_host.sv
// two-wire bus master model, 160 ns bus clock
// sda is the resolved wire level with pull-up
`timescale 1ns/1ps
module ldb_i2c_host (
  input wire logic pclk,   // bench clock
  input wire logic sda,    // resolved sda level
  output logic     scl,    // bus clock, idle high
  output logic     sda_drv // 0 pulls sda low
);
  // bus idle: both lines released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // quarter of a bus clock period
  task automatic q;
    repeat (8) @(posedge pclk);
  endtask : q
  // sda falls while scl high
  task automatic start;
    sda_drv <= 1'b1;
    scl <= 1'b1;
    q;
    sda_drv <= 1'b0;
    q;
    scl <= 1'b0;
    q;
  endtask : start
  // eight bits msb first, then sample the ack
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_drv <= b[i];
      q;
      scl <= 1'b1;
      q;
      q;
      scl <= 1'b0;
      q;
    end
    sda_drv <= 1'b1;
    q;
    scl <= 1'b1;
    q;
    ack = ~sda;
    q;
    scl <= 1'b0;
    q;
  endtask : wr_byte
  // sda rises while scl high
  task automatic stop;
    sda_drv <= 1'b0;
    q;
    scl <= 1'b1;
    q;
    sda_drv <= 1'b1;
    q;
  endtask : stop
endmodule : ldb_i2c_host

//--- verification/led_driver_bus_reset_fault_pwm_bench.sv
// self-checking bench for the led driver control block
// apb master, sensor levels and a two-wire host model
`timescale 1ns/1ps
module led_driver_bus_reset_fault_pwm_bench;
  import ldb_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rst_pin_n;
  logic        scl;
  logic        sda_drv;
  logic        sda_out;
  logic        sda_oe;
  ldb_sense_t  sense;
  logic [15:0] led_out;
  int          n_errors = 0;
  int          num_checks = 0;
  // open-drain wire with pull-up
  wire sda = (sda_oe ? sda_out : 1'b1) & sda_drv;

  ldb_top #(.BLINK_STEP_CYC(4)) ldb_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rst_pin_n(rst_pin_n),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .sense(sense), .led_out(led_out));
  ldb_i2c_host ldb_i2c_host_i (
    .pclk(pclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  task automatic check(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  // one apb transfer, waits for ready under a bound
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      summarize;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] x,
                     input string m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(r, x, m);
  endtask : rdc
  // cycles a channel is on within a window
  task automatic cnt(input int ch, input int n, input int x, string m);
    int c;
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      c += led_out[ch];
    end
    check(32'(c), 32'(x), m);
  endtask : cnt

  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rdc(OFS_MODE_CONTROL_SECOND, 32'h0000_0000, "mode rst");
    rdc(OFS_LATCH, 32'h0000_0000, "latch rst");
    rdc(OFS_EFLAG_HI, 32'h0000_00FF, "hi rst");
    rdc(OFS_EFLAG_LO, 32'h0000_00FF, "lo rst");
    apb(1'b0, 12'h0FC, 32'h0000_0000, r, e);
    check(32'(e), 32'h0000_0001, "unmapped");
  endtask : t_reset
  // duty table, then group dimming and blinking at zero
  task automatic t_pwm;
    int duty[4] = '{0, 1, 128, 255};
    wr(OFS_LATCH, 32'h0000_0001);
    foreach (duty[i]) begin
      wr(OFS_DUTY_BASE, 32'(duty[i]));
      tick(2048);
      cnt(0, 2048, duty[i] * 8, "duty");
    end
    wr(OFS_MODE_CONTROL_SECOND, 32'h0000_0001);
    tick(2048);
    cnt(0, 2048, 0, "group dim");
    wr(OFS_GRP_DUTY, 32'h0000_00FF);
    cnt(0, 2048, 2040, "dim full");
    wr(OFS_GRP_DUTY, 32'h0000_0000);
    wr(OFS_BLINK, 32'h0000_0003);
    rdc(OFS_BLINK, 32'h0000_0003, "blink period");
    wr(OFS_MODE_CONTROL_SECOND, 32'h0000_0021);
    tick(2048);
    cnt(0, 2048, 0, "group blink");
    wr(OFS_MODE_CONTROL_SECOND, 32'h0000_0000);
  endtask : t_pwm
  task automatic t_fault;
    wr(OFS_LATCH, 32'h0000_FFFF);
    wr(OFS_DUTY_BASE + 12'h00C, 32'h0000_00FF);
    sense.chan_hot[3] <= 1'b1;
    tick(20);
    rdc(OFS_EFLAG_LO, 32'h0000_00F7, "chan hot");
    cnt(3, 512, 0, "hot off");
    sense.chan_hot[3] <= 1'b0;
    tick(20);
    cnt(3, 2048, 2040, "restart");
    rdc(OFS_EFLAG_LO, 32'h0000_00F7, "latched");
    wr(OFS_MODE_CONTROL_SECOND, 32'h0000_0080);
    rdc(OFS_EFLAG_LO, 32'h0000_00FF, "cleared");
    wr(OFS_MODE_CONTROL_SECOND, 32'h0000_0000);
    sense.glob_hot <= 1'b1;
    tick(20);
    check(32'(led_out), 32'h0000_0000, "glob off");
    rdc(OFS_EFLAG_HI, 32'h0000_0000, "glob hi");
    rdc(OFS_EFLAG_LO, 32'h0000_0000, "glob lo");
    rdc(OFS_STATUS, 32'h0000_000C, "status");
    sense.glob_hot <= 1'b0;
    wr(OFS_MODE_CONTROL_SECOND, 32'h0000_0080);
    wr(OFS_MODE_CONTROL_SECOND, 32'h0000_0000);
    rdc(OFS_EFLAG_HI, 32'h0000_00FF, "reinit");
    sense.chan_open[9] <= 1'b1;
    tick(20);
    rdc(OFS_EFLAG_HI, 32'h0000_00FD, "open");
    wr(OFS_LATCH, 32'h0000_FDFF);
    sense.chan_hot[9] <= 1'b1;
    tick(20);
    rdc(OFS_EFLAG_HI, 32'h0000_00FF, "off ch");
    sense <= '0;
    tick(20);
  endtask : t_fault
  // reset call: bytes, count, expected acks, group duty after
  task automatic t_call(input logic [31:0] b, input int n,
                        input logic [3:0] acks, input logic [7:0] g);
    logic a;
    ldb_i2c_host_i.start;
    for (int i = 0; i < n; i++) begin
      ldb_i2c_host_i.wr_byte(b[31-8*i -: 8], a);
      check(32'(a), 32'(acks[3-i]), "ack");
    end
    ldb_i2c_host_i.stop;
    tick(20);
    rdc(OFS_GRP_DUTY, 32'(g), "after call");
  endtask : t_call
  task automatic t_pin;
    wr(OFS_GRP_DUTY, 32'h0000_0033);
    rst_pin_n <= 1'b0;
    tick(10);
    wr(OFS_GRP_DUTY, 32'h0000_0044);
    rst_pin_n <= 1'b1;
    tick(10);
    rdc(OFS_GRP_DUTY, 32'h0000_0000, "pin reset");
  endtask : t_pin

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rst_pin_n = 1'b1;
    sense = '0;
    tick(20);
    presetn <= 1'b1;
    tick(2);
    t_reset;
    t_pwm;
    t_fault;
    wr(OFS_GRP_DUTY, 32'h0000_0055);
    t_call(32'hD700_0000, 1, 4'b0000, 8'h55);
    t_call(32'hD600_0000, 2, 4'b1000, 8'h55);
    t_call(32'hD6A5_5B00, 3, 4'b1100, 8'h55);
    t_call(32'hD6A5_5A00, 4, 4'b1110, 8'h55);
    t_call(32'hD6A5_5A00, 3, 4'b1110, 8'h00);
    t_pin;
    summarize;
  end
endmodule : led_driver_bus_reset_fault_pwm_bench
